// file: rtl/pdma_pkg.sv
/*
 * Constants for the peripheral DMA channel pair: register offsets, field
 * positions, reset values and transfer sizes.
 * Assumes an APB slave with 32-bit data sitting in the owning peripheral space.
 */
package pdma_pkg;
	localparam logic [11:0] OFS_RX_PTR    = 12'h100;
	localparam logic [11:0] OFS_RX_CNT    = 12'h104;
	localparam logic [11:0] OFS_TX_PTR    = 12'h108;
	localparam logic [11:0] OFS_TX_CNT    = 12'h10C;
	localparam logic [11:0] OFS_RX_NPTR   = 12'h110;
	localparam logic [11:0] OFS_RX_NCNT   = 12'h114;
	localparam logic [11:0] OFS_TX_NPTR   = 12'h118;
	localparam logic [11:0] OFS_TX_NCNT   = 12'h11C;
	localparam logic [11:0] OFS_CONTROL   = 12'h120;
	localparam logic [11:0] OFS_STATUS    = 12'h124;

	localparam int BIT_RX_EN  = 0;
	localparam int BIT_RX_DIS = 1;
	localparam int BIT_TX_EN  = 8;
	localparam int BIT_TX_DIS = 9;

	localparam logic [31:0] PTR_RESET = 32'h0000_0000;
	localparam logic [15:0] CNT_RESET = 16'h0000;

	localparam logic [1:0] SIZE_BYTE = 2'h0;
	localparam logic [1:0] SIZE_HALF = 2'h1;
	localparam logic [1:0] SIZE_WORD = 2'h2;

	typedef enum logic [3:0] {
		PDMA_IDLE  = 4'b0001,
		PDMA_READ  = 4'b0010,
		PDMA_WRITE = 4'b0100,
		PDMA_DONE  = 4'b1000
	} pdma_state_type;
endpackage

// file: rtl/pdma_channel_pair.sv
/*
 * One receive/transmit channel pair of a peripheral DMA engine with its
 * APB register file. Each transfer reads one item from a source and writes
 * it to a destination over a simple request/grant memory port.
 * Assumes triggers come from logic on CLK_SYS and stay high until served,
 * and that the memory port answers with MEM_READY in its own time.
 */
// Chosen here: the APB interface to the registers.
module pdma_channel_pair
	import pdma_pkg::*;
(
	input  wire logic        CLK_SYS,
	input  wire logic        RESETN,
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [11:0] PADDR,
	input  wire logic [31:0] PWDATA,
	output logic      [31:0] PRDATA,
	output logic             PREADY,
	output logic             PSLVERR,
	input  wire logic [1:0]  XFER_SIZE,
	input  wire logic [31:0] RX_HOLD_ADDR,
	input  wire logic [31:0] TX_HOLD_ADDR,
	input  wire logic        RX_TRIGGER,
	input  wire logic        TX_TRIGGER,
	output logic             RX_SERVED,
	output logic             TX_SERVED,
	output logic             MEM_REQ,
	output logic             MEM_WRITE,
	output logic      [31:0] MEM_ADDR,
	output logic      [31:0] MEM_WDATA,
	input  wire logic [31:0] MEM_RDATA,
	input  wire logic        MEM_READY,
	output logic             RX_BUFFER_DONE_FLAG,
	output logic             RX_ALL_BUFFERS_FULL_FLAG,
	output logic             TX_BUFFER_DONE_FLAG,
	output logic             TX_ALL_BUFFERS_EMPTY_FLAG
);
	logic [31:0]    rx_ptr, tx_ptr, rx_nptr, tx_nptr;
	logic [15:0]    rx_cnt, tx_cnt, rx_ncnt, tx_ncnt;
	logic           rx_en, tx_en;
	logic           rx_done, tx_done;
	pdma_state_type state;
	logic           cur_is_tx;
	logic [31:0]    data_hold;
	logic [31:0]    step;
	logic           wr_acc, rd_acc, addr_ok;
	logic           xfer_end;
	logic           rx_cnt_wr, tx_cnt_wr;
	logic           rx_go, tx_go;

	// Slave answers in the access phase with no wait states
	assign PREADY  = 1'b1;
	assign wr_acc  = PSEL && PENABLE && PWRITE;
	assign rd_acc  = PSEL && PENABLE && !PWRITE;
	assign addr_ok = (PADDR >= OFS_RX_PTR) && (PADDR <= OFS_STATUS)
		&& (PADDR[1:0] == 2'h0);
	assign PSLVERR = PSEL && PENABLE && (!addr_ok || (PWRITE && PADDR == OFS_STATUS));

	assign rx_cnt_wr = wr_acc && (PADDR == OFS_RX_CNT || PADDR == OFS_RX_NCNT);
	assign tx_cnt_wr = wr_acc && (PADDR == OFS_TX_CNT || PADDR == OFS_TX_NCNT);

	always_comb begin
		unique case (XFER_SIZE)
			SIZE_HALF: step = 32'h0000_0002;
			SIZE_WORD: step = 32'h0000_0004;
			default:   step = 32'h0000_0001;
		endcase
	end

	// Receive has priority over transmit when both are pending
	assign rx_go = rx_en && (rx_cnt != CNT_RESET) && RX_TRIGGER;
	assign tx_go = tx_en && (tx_cnt != CNT_RESET) && TX_TRIGGER;
	assign xfer_end = (state == PDMA_WRITE) && MEM_READY;

	always_ff @(posedge CLK_SYS or negedge RESETN) begin
		if (!RESETN) begin
			state     <= PDMA_IDLE;
			cur_is_tx <= 1'b0;
			data_hold <= 32'h0000_0000;
		end else begin
			unique case (state)
				PDMA_IDLE: begin
					if (rx_go || tx_go) begin
						state     <= PDMA_READ;
						cur_is_tx <= !rx_go;
					end
				end
				PDMA_READ: begin
					if (MEM_READY) begin
						data_hold <= MEM_RDATA;
						state     <= PDMA_WRITE;
					end
				end
				PDMA_WRITE: begin
					if (MEM_READY) begin
						state <= PDMA_DONE;
					end
				end
				PDMA_DONE: begin
					state <= PDMA_IDLE;
				end
				default: state <= PDMA_IDLE;
			endcase
		end
	end

	// Receive reads holding register then writes memory; transmit is the reverse
	always_comb begin
		MEM_REQ   = (state == PDMA_READ) || (state == PDMA_WRITE);
		MEM_WRITE = (state == PDMA_WRITE);
		MEM_WDATA = data_hold;
		if (state == PDMA_READ) begin
			MEM_ADDR = cur_is_tx ? tx_ptr : RX_HOLD_ADDR;
		end else begin
			MEM_ADDR = cur_is_tx ? TX_HOLD_ADDR : rx_ptr;
		end
	end

	assign RX_SERVED = (state == PDMA_DONE) && !cur_is_tx;
	assign TX_SERVED = (state == PDMA_DONE) && cur_is_tx;

	// Both bits set leaves the direction disabled
	always_ff @(posedge CLK_SYS or negedge RESETN) begin
		if (!RESETN) begin
			rx_en <= 1'b0;
			tx_en <= 1'b0;
		end else if (wr_acc && PADDR == OFS_CONTROL) begin
			if (PWDATA[BIT_RX_DIS]) begin
				rx_en <= 1'b0;
			end else if (PWDATA[BIT_RX_EN]) begin
				rx_en <= 1'b1;
			end
			if (PWDATA[BIT_TX_DIS]) begin
				tx_en <= 1'b0;
			end else if (PWDATA[BIT_TX_EN]) begin
				tx_en <= 1'b1;
			end
		end
	end

	// Software write wins over a same-cycle hardware update of the same register
	always_ff @(posedge CLK_SYS or negedge RESETN) begin
		if (!RESETN) begin
			rx_ptr  <= PTR_RESET;
			rx_cnt  <= CNT_RESET;
			rx_nptr <= PTR_RESET;
			rx_ncnt <= CNT_RESET;
		end else begin
			// Without a next buffer the pointer still advances past the last item
			if (xfer_end && !cur_is_tx) begin
				if (rx_cnt == 16'h0001 && rx_ncnt != CNT_RESET) begin
					rx_ptr  <= rx_nptr;
					rx_cnt  <= rx_ncnt;
					rx_ncnt <= CNT_RESET;
				end else begin
					rx_ptr <= rx_ptr + step;
					rx_cnt <= rx_cnt - 16'h0001;
				end
			end
			if (wr_acc && PADDR == OFS_RX_PTR) rx_ptr <= PWDATA;
			if (wr_acc && PADDR == OFS_RX_CNT) rx_cnt <= PWDATA[15:0];
			if (wr_acc && PADDR == OFS_RX_NPTR) rx_nptr <= PWDATA;
			if (wr_acc && PADDR == OFS_RX_NCNT) rx_ncnt <= PWDATA[15:0];
		end
	end

	always_ff @(posedge CLK_SYS or negedge RESETN) begin
		if (!RESETN) begin
			tx_ptr  <= PTR_RESET;
			tx_cnt  <= CNT_RESET;
			tx_nptr <= PTR_RESET;
			tx_ncnt <= CNT_RESET;
		end else begin
			if (xfer_end && cur_is_tx) begin
				if (tx_cnt == 16'h0001 && tx_ncnt != CNT_RESET) begin
					tx_ptr  <= tx_nptr;
					tx_cnt  <= tx_ncnt;
					tx_ncnt <= CNT_RESET;
				end else begin
					tx_ptr <= tx_ptr + step;
					tx_cnt <= tx_cnt - 16'h0001;
				end
			end
			if (wr_acc && PADDR == OFS_TX_PTR) tx_ptr <= PWDATA;
			if (wr_acc && PADDR == OFS_TX_CNT) tx_cnt <= PWDATA[15:0];
			if (wr_acc && PADDR == OFS_TX_NPTR) tx_nptr <= PWDATA;
			if (wr_acc && PADDR == OFS_TX_NCNT) tx_ncnt <= PWDATA[15:0];
		end
	end

	// Sticky until a counter write; a same-cycle last transfer of a buffer (count at one, chained or not) wins
	always_ff @(posedge CLK_SYS or negedge RESETN) begin
		if (!RESETN) begin
			rx_done <= 1'b0;
			tx_done <= 1'b0;
		end else begin
			if (xfer_end && !cur_is_tx && rx_cnt == 16'h0001) begin
				rx_done <= 1'b1;
			end else if (rx_cnt_wr) begin
				rx_done <= 1'b0;
			end
			if (xfer_end && cur_is_tx && tx_cnt == 16'h0001) begin
				tx_done <= 1'b1;
			end else if (tx_cnt_wr) begin
				tx_done <= 1'b0;
			end
		end
	end

	// Both-buffers flags follow the counters, so a nonzero counter write clears them too
	assign RX_BUFFER_DONE_FLAG       = rx_done;
	assign TX_BUFFER_DONE_FLAG       = tx_done;
	assign RX_ALL_BUFFERS_FULL_FLAG  = (rx_cnt == CNT_RESET) && (rx_ncnt == CNT_RESET);
	assign TX_ALL_BUFFERS_EMPTY_FLAG = (tx_cnt == CNT_RESET) && (tx_ncnt == CNT_RESET);

	always_ff @(posedge CLK_SYS or negedge RESETN) begin
		if (!RESETN) begin
			PRDATA <= 32'h0000_0000;
		end else if (PSEL && !PENABLE && !PWRITE) begin
			unique case (PADDR)
				OFS_RX_PTR:  PRDATA <= rx_ptr;
				OFS_RX_CNT:  PRDATA <= {16'h0000, rx_cnt};
				OFS_TX_PTR:  PRDATA <= tx_ptr;
				OFS_TX_CNT:  PRDATA <= {16'h0000, tx_cnt};
				OFS_RX_NPTR: PRDATA <= rx_nptr;
				OFS_RX_NCNT: PRDATA <= {16'h0000, rx_ncnt};
				OFS_TX_NPTR: PRDATA <= tx_nptr;
				OFS_TX_NCNT: PRDATA <= {16'h0000, tx_ncnt};
				OFS_STATUS:  PRDATA <= {23'h000000, tx_en, 7'h00, rx_en};
				default:     PRDATA <= 32'h0000_0000;
			endcase
		end
	end

	a_rx_enable_write: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
		(wr_acc && PADDR == OFS_CONTROL && PWDATA[1:0] == 2'b01) |=> rx_en)
		else $error("receive enable write ignored");
	a_rx_disable_write: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
		(wr_acc && PADDR == OFS_CONTROL && PWDATA[BIT_RX_DIS]) |=> !rx_en)
		else $error("receive disable write ignored");
	a_tx_both_bits: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
		(wr_acc && PADDR == OFS_CONTROL && PWDATA[9:8] == 2'b11) |=> !tx_en)
		else $error("transmit both bits left enabled");
	a_no_serve_disabled: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
		(state == PDMA_IDLE && !(rx_go || tx_go)) |=> state == PDMA_IDLE)
		else $error("transfer started without enabled request");
	a_ptr_advance_step: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
		(xfer_end && !cur_is_tx && rx_cnt > 16'h0001 && !wr_acc)
		|=> rx_ptr == $past(rx_ptr) + $past(step))
		else $error("receive pointer did not advance by size");
	a_cnt_chain_load: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
		(xfer_end && cur_is_tx && tx_cnt == 16'h0001 && !wr_acc)
		|=> tx_cnt == $past(tx_ncnt) && tx_ncnt == CNT_RESET)
		else $error("transmit chain load wrong");
	a_done_flag_set: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
		(xfer_end && !cur_is_tx && rx_cnt == 16'h0001) |=> RX_BUFFER_DONE_FLAG)
		else $error("receive done flag not raised");
	a_flag_clear_write: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
		(tx_cnt_wr && !xfer_end) |=> !TX_BUFFER_DONE_FLAG)
		else $error("transmit done flag not cleared by count write");
	a_status_read: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
		(PSEL && !PENABLE && !PWRITE && PADDR == OFS_STATUS)
		|=> PRDATA[8] == $past(tx_en) && PRDATA[0] == $past(rx_en))
		else $error("status read mismatch");
	// Register checks exclude same-cycle bus writes, which win over hardware updates
	a_control_read_zero: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
		(rd_acc && PADDR == OFS_CONTROL)
		|-> PRDATA == 32'h0000_0000)
		else $error("control register read not zero");
	a_status_write_err: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
		(wr_acc && PADDR == OFS_STATUS)
		|-> PSLVERR)
		else $error("status write not refused");
	a_unmapped_err: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
		(PSEL && PENABLE && (PADDR < OFS_RX_PTR || PADDR > OFS_STATUS))
		|-> PSLVERR)
		else $error("unmapped access not refused");
	a_mapped_read_ok: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
		(PSEL && PENABLE && addr_ok && !PWRITE)
		|-> !PSLVERR)
		else $error("mapped read refused");
	a_rx_ptr_write: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
		(wr_acc && PADDR == OFS_RX_PTR)
		|=> rx_ptr == $past(PWDATA))
		else $error("receive pointer write lost");
	a_rx_cnt_write: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
		(wr_acc && PADDR == OFS_RX_CNT)
		|=> rx_cnt == $past(PWDATA[15:0]))
		else $error("receive counter write lost");
	a_tx_ptr_write: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
		(wr_acc && PADDR == OFS_TX_PTR)
		|=> tx_ptr == $past(PWDATA))
		else $error("transmit pointer write lost");
	a_tx_cnt_write: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
		(wr_acc && PADDR == OFS_TX_CNT)
		|=> tx_cnt == $past(PWDATA[15:0]))
		else $error("transmit counter write lost");
	a_rx_nptr_write: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
		(wr_acc && PADDR == OFS_RX_NPTR)
		|=> rx_nptr == $past(PWDATA))
		else $error("receive next pointer write lost");
	a_rx_ncnt_write: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
		(wr_acc && PADDR == OFS_RX_NCNT)
		|=> rx_ncnt == $past(PWDATA[15:0]))
		else $error("receive next counter write lost");
	a_tx_nptr_write: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
		(wr_acc && PADDR == OFS_TX_NPTR)
		|=> tx_nptr == $past(PWDATA))
		else $error("transmit next pointer write lost");
	a_tx_ncnt_write: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
		(wr_acc && PADDR == OFS_TX_NCNT)
		|=> tx_ncnt == $past(PWDATA[15:0]))
		else $error("transmit next counter write lost");
	a_tx_enable_write: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
		(wr_acc && PADDR == OFS_CONTROL && PWDATA[9:8] == 2'b01)
		|=> tx_en)
		else $error("transmit enable write ignored");
	a_tx_disable_write: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
		(wr_acc && PADDR == OFS_CONTROL && PWDATA[BIT_TX_DIS])
		|=> !tx_en)
		else $error("transmit disable write ignored");
	a_rx_both_bits: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
		(wr_acc && PADDR == OFS_CONTROL && PWDATA[1:0] == 2'b11)
		|=> !rx_en)
		else $error("receive both bits left enabled");
	a_enable_hold: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
		!(wr_acc && PADDR == OFS_CONTROL)
		|=> rx_en == $past(rx_en) && tx_en == $past(tx_en))
		else $error("enable changed without control write");
	a_tx_stop_zero: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
		(state == PDMA_IDLE && tx_cnt == CNT_RESET && !rx_go)
		|=> state == PDMA_IDLE)
		else $error("transfer started with zero transmit count");
	a_rx_refused: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
		(state == PDMA_IDLE && !rx_en && !tx_go)
		|=> state == PDMA_IDLE)
		else $error("disabled receive trigger served");
	a_tx_ptr_advance: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
		(xfer_end && cur_is_tx && tx_cnt > 16'h0001 && !wr_acc)
		|=> tx_ptr == $past(tx_ptr) + $past(step))
		else $error("transmit pointer did not advance by size");
	a_rx_cnt_decrement: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
		(xfer_end && !cur_is_tx && rx_cnt > 16'h0001 && !wr_acc)
		|=> rx_cnt == $past(rx_cnt) - 16'h0001)
		else $error("receive counter did not decrement");
	a_rx_chain_load: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
		(xfer_end && !cur_is_tx && rx_cnt == 16'h0001 && rx_ncnt != CNT_RESET && !wr_acc)
		|=> rx_ptr == $past(rx_nptr) && rx_cnt == $past(rx_ncnt) && rx_ncnt == CNT_RESET)
		else $error("receive chain load wrong");
	a_rx_last_advance: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
		(xfer_end && !cur_is_tx && rx_cnt == 16'h0001 && rx_ncnt == CNT_RESET && !wr_acc)
		|=> rx_ptr == $past(rx_ptr) + $past(step) && rx_cnt == CNT_RESET)
		else $error("receive last transfer wrong");
	a_tx_done_set: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
		(xfer_end && cur_is_tx && tx_cnt == 16'h0001)
		|=> TX_BUFFER_DONE_FLAG)
		else $error("transmit done flag not raised");
	a_rx_flag_clear: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
		(rx_cnt_wr && !xfer_end)
		|=> !RX_BUFFER_DONE_FLAG)
		else $error("receive done flag not cleared by count write");
	a_rx_done_sticky: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
		(RX_BUFFER_DONE_FLAG && !rx_cnt_wr)
		|=> RX_BUFFER_DONE_FLAG)
		else $error("receive done flag dropped");
	a_tx_done_sticky: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
		(TX_BUFFER_DONE_FLAG && !tx_cnt_wr)
		|=> TX_BUFFER_DONE_FLAG)
		else $error("transmit done flag dropped");
	a_rx_regs_hold: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
		(!(xfer_end && !cur_is_tx) && !wr_acc)
		|=> rx_ptr == $past(rx_ptr) && rx_cnt == $past(rx_cnt))
		else $error("receive registers changed without cause");
	a_tx_regs_hold: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
		(!(xfer_end && cur_is_tx) && !wr_acc)
		|=> tx_ptr == $past(tx_ptr) && tx_cnt == $past(tx_cnt))
		else $error("transmit registers changed without cause");
endmodule // pdma_channel_pair

// file: verif/pdma_mem_model.sv
/*
 * Memory side of the channel pair: completes each beat at once or two cycles late.
 * Assumes the channel holds MEM_REQ, MEM_WRITE and MEM_ADDR until MEM_READY.
 */
module pdma_mem_model (
	input  wire logic        clk,
	input  wire logic        rstn,
	input  wire logic        slow,
	input  wire logic        mem_req,
	input  wire logic        mem_write,
	input  wire logic [31:0] mem_addr,
	input  wire logic [31:0] mem_wdata,
	output logic      [31:0] mem_rdata,
	output logic             mem_ready,
	output logic      [31:0] wr_addr,
	output logic      [31:0] wr_data,
	output logic      [15:0] beats
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] wait_n;
	assign mem_ready = mem_req && wait_n == 2'h0;
	// Data is only valid with ready; otherwise the inverse, so a stale capture shows
	assign mem_rdata = mem_ready ? mem_addr ^ 32'h5A5A0F0F : ~(mem_addr ^ 32'h5A5A0F0F);
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			wait_n <= 2'h0;
			beats <= 16'h0;
		end else if (mem_req && !mem_ready) begin
			wait_n <= wait_n - 2'h1;
		end else begin
			wait_n <= slow ? 2'h2 : 2'h0;
			beats <= beats + 16'(mem_req);
		end
	end
	always_ff @(posedge clk) begin
		if (mem_req && mem_ready && mem_write) begin
			wr_addr <= mem_addr;
			wr_data <= mem_wdata;
		end
	end
endmodule // pdma_mem_model

// file: verif/peripheral_dma_channel_pair_test.sv
/*
 * Self-checking bench for the DMA channel pair: registers over APB, rx chaining, tx.
 * Assumes pdma_mem_model as the memory and the bench acting as the peripheral.
 */
module peripheral_dma_channel_pair_test
	import pdma_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic        CLK_SYS = 0, RESETN = 0, PSEL = 0, PENABLE = 0, PWRITE = 0, slow = 0;
	logic        RX_TRIGGER = 0, TX_TRIGGER = 0, err;
	logic [11:0] PADDR = 12'h000;
	logic [1:0]  XFER_SIZE = 2'h0;
	logic [31:0] PWDATA = 0, RX_HOLD_ADDR = 0, TX_HOLD_ADDR = 0, rd, p, q, v;
	logic [31:0] seed = 32'h55579DD1;
	logic [31:0] cw [7] = '{32'h1, 32'h100, 32'h3, 32'h0, 32'h300, 32'h101, 32'h202};
	logic [31:0] cs [7] = '{32'h1, 32'h101, 32'h100, 32'h100, 32'h0, 32'h101, 32'h0};
	wire logic [31:0] PRDATA, MEM_ADDR, MEM_WDATA, MEM_RDATA, wr_addr, wr_data;
	wire logic        PREADY, PSLVERR, RX_SERVED, TX_SERVED, MEM_REQ, MEM_WRITE, MEM_READY;
	wire logic        rxd, rxf, txd, txe;
	wire logic [15:0] beats;
	logic [15:0]      b0;
	int               fail_count = 0, n_checks = 0;
	always #5 CLK_SYS = ~CLK_SYS;
	pdma_channel_pair dut (.CLK_SYS(CLK_SYS), .RESETN(RESETN), .PSEL(PSEL), .PENABLE(PENABLE),
		.PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
		.PSLVERR(PSLVERR), .XFER_SIZE(XFER_SIZE), .RX_HOLD_ADDR(RX_HOLD_ADDR),
		.TX_HOLD_ADDR(TX_HOLD_ADDR), .RX_TRIGGER(RX_TRIGGER), .TX_TRIGGER(TX_TRIGGER),
		.RX_SERVED(RX_SERVED), .TX_SERVED(TX_SERVED), .MEM_REQ(MEM_REQ), .MEM_WRITE(MEM_WRITE),
		.MEM_ADDR(MEM_ADDR), .MEM_WDATA(MEM_WDATA), .MEM_RDATA(MEM_RDATA),
		.MEM_READY(MEM_READY), .RX_BUFFER_DONE_FLAG(rxd), .RX_ALL_BUFFERS_FULL_FLAG(rxf),
		.TX_BUFFER_DONE_FLAG(txd), .TX_ALL_BUFFERS_EMPTY_FLAG(txe));
	pdma_mem_model mem (.clk(CLK_SYS), .rstn(RESETN), .slow(slow), .mem_req(MEM_REQ),
		.mem_write(MEM_WRITE), .mem_addr(MEM_ADDR), .mem_wdata(MEM_WDATA),
		.mem_rdata(MEM_RDATA), .mem_ready(MEM_READY), .wr_addr(wr_addr), .wr_data(wr_data),
		.beats(beats));
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic logic [31:0] md(input logic [31:0] a);
		return a ^ 32'h5A5A0F0F;
	endfunction
	function automatic logic [31:0] inc(input logic [1:0] s);
		return s == SIZE_HALF ? 32'h2 : s == SIZE_WORD ? 32'h4 : 32'h1;
	endfunction
	task automatic stop_test();
		if (fail_count == 0 && n_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			fail_count++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		PSEL <= 1'b1;
		PWRITE <= w;
		PADDR <= a;
		PWDATA <= d;
		@(posedge CLK_SYS);
		PENABLE <= 1'b1;
		n = 0;
		do begin
			@(posedge CLK_SYS);
			n++;
		end while (PREADY !== 1'b1 && n < 50);
		rd = PRDATA;
		err = PSLVERR;
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
		@(posedge CLK_SYS);
		if (n >= 50) begin
			fail_count++;
			stop_test();
		end
	endtask
	// Trigger falls at the edge that shows the pulse, so it is not served twice
	task automatic xfer(input logic rx);
		int n;
		RX_TRIGGER <= rx;
		TX_TRIGGER <= !rx;
		n = 0;
		do begin
			@(posedge CLK_SYS);
			n++;
		end while ((rx ? RX_SERVED : TX_SERVED) !== 1'b1 && n < 40);
		RX_TRIGGER <= 1'b0;
		TX_TRIGGER <= 1'b0;
		if (n >= 40) begin
			fail_count++;
			stop_test();
		end
		@(posedge CLK_SYS);
	endtask
	task automatic refuse(input logic rx);
		RX_TRIGGER <= rx;
		TX_TRIGGER <= !rx;
		b0 = beats;
		repeat (8) @(posedge CLK_SYS);
		chk("refused beats", b0, beats);
		RX_TRIGGER <= 1'b0;
		TX_TRIGGER <= 1'b0;
		@(posedge CLK_SYS);
	endtask
	initial begin
		RX_HOLD_ADDR <= rnd();
		TX_HOLD_ADDR <= rnd();
		repeat (6) @(posedge CLK_SYS);
		RESETN <= 1'b1;
		@(posedge CLK_SYS);
		chk("rx all full", 1, rxf);
		chk("tx all empty", 1, txe);
		for (int i = 0; i < 10; i++) begin
			apb(1'b0, OFS_RX_PTR + 12'(4 * i), 0);
			chk("reset value", 0, rd);
			chk("reset read err", 0, err);
		end
		for (int i = 0; i < 8; i++) begin
			v = rnd();
			apb(1'b1, OFS_RX_PTR + 12'(4 * i), v);
			apb(1'b0, OFS_RX_PTR + 12'(4 * i), 0);
			chk("reg rw", i[0] ? {16'h0000, v[15:0]} : v, rd);
		end
		apb(1'b1, OFS_STATUS, 32'hFFFFFFFF);
		chk("status write err", 1, err);
		apb(1'b0, 12'h128, 0);
		chk("unmapped err", 1, err);
		for (int i = 0; i < 7; i++) begin
			apb(1'b1, OFS_CONTROL, cw[i]);
			apb(1'b0, OFS_STATUS, 0);
			chk("status", cs[i], rd);
		end
		refuse(1'b1);
		refuse(1'b0);
		v = rnd();
		p = rnd() & 32'hFFFFFFF0;
		q = rnd() & 32'hFFFFFFF0;
		XFER_SIZE <= 2'(v % 3);
		slow <= v[8];
		apb(1'b1, OFS_RX_PTR, p);
		apb(1'b1, OFS_RX_CNT, 2);
		apb(1'b1, OFS_RX_NPTR, q);
		apb(1'b1, OFS_RX_NCNT, 1);
		apb(1'b1, OFS_CONTROL, 32'h1);
		for (int i = 0; i < 3; i++) begin
			xfer(1'b1);
			chk("rx waddr", i == 2 ? q : p + inc(XFER_SIZE) * i, wr_addr);
			chk("rx wdata", md(RX_HOLD_ADDR), wr_data);
			if (i == 1) begin
				apb(1'b0, OFS_RX_PTR, 0);
				chk("rx chained ptr", q, rd);
				apb(1'b0, OFS_RX_CNT, 0);
				chk("rx chained cnt", 1, rd);
				apb(1'b0, OFS_RX_NCNT, 0);
				chk("rx next cleared", 0, rd);
				chk("rx done", 1, rxd);
				chk("rx full early", 0, rxf);
			end
		end
		apb(1'b0, OFS_RX_PTR, 0);
		chk("rx ptr end", q + inc(XFER_SIZE), rd);
		chk("rx full", 1, rxf);
		apb(1'b1, OFS_RX_NCNT, 0);
		chk("rx done cleared", 0, rxd);
		refuse(1'b1);
		slow <= 1'b1;
		XFER_SIZE <= XFER_SIZE + 2'h1;
		apb(1'b1, OFS_TX_PTR, p);
		apb(1'b1, OFS_TX_CNT, 1);
		apb(1'b1, OFS_TX_NCNT, 0);
		apb(1'b1, OFS_CONTROL, 32'h100);
		xfer(1'b0);
		chk("tx waddr", TX_HOLD_ADDR, wr_addr);
		chk("tx wdata", md(p), wr_data);
		apb(1'b0, OFS_TX_PTR, 0);
		chk("tx ptr end", p + inc(XFER_SIZE), rd);
		chk("tx done", 1, txd);
		chk("tx all empty end", 1, txe);
		refuse(1'b0);
		apb(1'b1, OFS_TX_CNT, 0);
		chk("tx done cleared", 0, txd);
		stop_test();
	end
endmodule // peripheral_dma_channel_pair_test
